// ===== test/tccs_pins_model.sv
`timescale 1ns/1ns
`default_nettype none
module tccs_pins_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [3:0] run,
    output logic [3:0] pins
);
    logic [3:0] ph_ff;
    logic [3:0] pins_ff;
    assign pins = pins_ff;
    // Board pins toggle every second cycle while run, level otherwise
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ph_ff <= 4'h0;
            pins_ff <= 4'h0;
        end else begin
            ph_ff <= ph_ff ^ run;
            pins_ff <= pins_ff ^ (run & ph_ff);
        end
    end
endmodule // tccs_pins_model
`default_nettype wire

// ===== test/tccs_top_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module tccs_top_monitor
    import tccs_pkg::*;
#(parameter int NUM_CH = TCCS_NUM_CH) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [TCCS_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic standby,
    input wire logic ext_count_clock_a,
    input wire logic ext_count_clock_b,
    input wire logic ext_count_clock_c,
    input wire logic ext_count_clock_d,
    input wire logic phase_count_tick,
    input wire tccs_gr_evt_t [NUM_CH-1:0] gr_evt,
    input wire logic [NUM_CH-1:0] count_tick,
    input wire logic [NUM_CH-1:0] counter_clear
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    tccs_ctrl_t c0_ff;
    logic [3:0] pin_v;
    logic pin0;
    logic wr0;
    assign pin_v = {ext_count_clock_d, ext_count_clock_c, ext_count_clock_b, ext_count_clock_a};
    assign pin0 = pin_v[c0_ff.clk_src[1:0]];
    assign wr0 = psel && penable && pready && pwrite && paddr == TCCS_OFF_CTRL0;
    // Shadow of channel 0 control
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) c0_ff <= TCCS_CTRL_RST;
        else if (standby) c0_ff <= TCCS_CTRL_RST;
        else if (wr0) c0_ff <= pwdata[7:0];
    end
    apb_wait_a: assert property (psel && penable && !pready |=> pready)
        else $error("no ready after access");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    standby_quiet_a: assert property (standby |=> count_tick == '0 && counter_clear == '0)
        else $error("activity in standby");
    no_clear_a: assert property (c0_ff.clr_sel == TCCS_CLR_NONE |=> !counter_clear[0])
        else $error("clear with no source");
    match_clear_a: assert property (c0_ff.clr_sel == TCCS_CLR_GRA && gr_evt[0].gra_match
        && !gr_evt[0].gra_is_capture && !standby |=> counter_clear[0]) else $error("match clear missing");
    cap_clear_a: assert property (c0_ff.clr_sel == TCCS_CLR_GRB && gr_evt[0].grb_is_capture
        && gr_evt[0].grb_capture && !standby |=> counter_clear[0]) else $error("capture clear missing");
    div1_tick_a: assert property (c0_ff.clk_src == TCCS_SRC_DIV1 && !standby |=> count_tick[0])
        else $error("system clock tick missing");
    ext_rise_a: assert property (c0_ff.clk_src[2] && c0_ff.edge_sel == 2'h0 && $stable(c0_ff)
        && pin0 && !$past(pin0) && !standby |=> count_tick[0]) else $error("rising edge not counted");
    fall_only_a: assert property (c0_ff.clk_src[2] && c0_ff.edge_sel == 2'h1 && $stable(c0_ff)
        && pin0 && !$past(pin0) |=> !count_tick[0]) else $error("rising edge counted");
    cover property (counter_clear[1]);
    cover property (count_tick[2]);
    cover property (pslverr);
endmodule // tccs_top_monitor
bind tccs_top tccs_top_monitor #(.NUM_CH(NUM_CH)) u_mon (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .standby, .ext_count_clock_a, .ext_count_clock_b, .ext_count_clock_c,
    .ext_count_clock_d, .phase_count_tick, .gr_evt, .count_tick, .counter_clear);
`default_nettype wire

// ===== test/tccs_top_tb.sv
`timescale 1ns/1ns
`default_nettype none
module tccs_top_tb
    import tccs_pkg::*;
;
    logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic standby = 1'h0, ph_tick = 1'h0, cnt_en = 1'h0, pready, pslverr, sv;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rv;
    logic [3:0] pins, run = 4'h0;
    logic [4:0] count_tick, counter_clear;
    tccs_gr_evt_t [4:0] gr_evt = '0;
    int error_cnt = 0, check_count = 0, tick_cnt = 0, cnt_ch = 0;
    always #25 pclk = ~pclk;
    tccs_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .standby, .ext_count_clock_a(pins[0]), .ext_count_clock_b(pins[1]), .ext_count_clock_c(pins[2]),
        .ext_count_clock_d(pins[3]), .phase_count_tick(ph_tick), .gr_evt, .count_tick, .counter_clear);
    tccs_pins_model pm (.pclk, .presetn, .run, .pins);
    always @(posedge pclk) if (cnt_en) tick_cnt <= tick_cnt + count_tick[cnt_ch];
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            $display("unexpected %s expected %h seen %h", n, e, g);
            error_cnt++;
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 20);
        rv = prdata;
        sv = pslverr;
        if (n >= 20) error_cnt++;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e, input logic es);
        apb(1'h0, a, 32'h0);
        chk("prdata", e, rv);
        chk("pslverr", {31'h0, es}, {31'h0, sv});
    endtask
    task win(input int ch, input logic [3:0] rm, input int xt, input int e);
        cnt_ch = ch;
        repeat (2) @(posedge pclk);
        tick_cnt <= 0;
        cnt_en <= 1'h1;
        run <= rm;
        repeat (32) @(posedge pclk);
        run <= 4'h0;
        repeat (xt) @(posedge pclk);
        cnt_en <= 1'h0;
        @(negedge pclk);
        chk("count_tick", e, tick_cnt);
    endtask
    task clr(input logic [7:0] c, input logic [5:0] ev, input logic [4:0] e);
        apb(1'h1, 8'h00, {24'h0, c});
        @(posedge pclk);
        gr_evt[0] <= ev;
        @(posedge pclk);
        gr_evt[0] <= 6'h00;
        @(negedge pclk);
        chk("counter_clear", {27'h0, e}, {27'h0, counter_clear});
    endtask
    task t_regs();
        for (int i = 0; i < 5; i++) rd(8'(4 * i), 32'h0, 1'h0);
        for (int i = 0; i < 5; i++) apb(1'h1, 8'(4 * i), 32'hFFFFFF00 | (32'hA5 ^ i));
        for (int i = 0; i < 5; i++) rd(8'(4 * i), 32'hA5 ^ i, 1'h0);
        rd(8'h1C, 32'h0, 1'h1);
        apb(1'h1, 8'h0C, 32'h5A);
        @(posedge pclk);
        standby <= 1'h1;
        repeat (2) @(posedge pclk);
        standby <= 1'h0;
        rd(8'h0C, 32'h0, 1'h0);
        for (int i = 0; i < 5; i++) apb(1'h1, 8'(4 * i), 32'h0);
        $display("registers done");
    endtask
    task t_clear();
        clr(8'h20, 6'h10, 5'h01);
        clr(8'h20, 6'h30, 5'h00);
        clr(8'h20, 6'h28, 5'h01);
        clr(8'h40, 6'h05, 5'h01);
        clr(8'h00, 6'h10, 5'h00);
        apb(1'h1, 8'h04, 32'h60);
        apb(1'h1, TCCS_OFF_SYNC, 32'h3);
        clr(8'h20, 6'h10, 5'h03);
        apb(1'h1, TCCS_OFF_SYNC, 32'h0);
        $display("clear done");
    endtask
    task t_clk();
        for (int k = 0; k < 4; k++) begin
            apb(1'h1, 8'h00, 32'(k));
            win(0, 4'h0, 0, 32 >> k);
        end
        for (int p = 0; p < 4; p++) begin
            apb(1'h1, 8'h00, 32'h14 + 32'(p));
            win(0, 4'h1 << p, 4, 16);
        end
        apb(1'h1, 8'h00, 32'h04);
        win(0, 4'h1, 4, 8);
        apb(1'h1, 8'h00, 32'h0C);
        win(0, 4'h1, 4, 8);
        apb(1'h1, 8'h00, 32'h18);
        win(0, 4'h1, 4, 36);
        $display("clock done");
    endtask
    task t_phase();
        apb(1'h1, TCCS_OFF_SYNC, 32'h100);
        apb(1'h1, 8'h08, 32'h1F);
        fork
            win(2, 4'h0, 0, 3);
            for (int k = 0; k < 3; k++) begin
                repeat (4) @(posedge pclk);
                ph_tick <= 1'h1;
                @(posedge pclk);
                ph_tick <= 1'h0;
            end
        join
        $display("phase done");
    endtask
    task report_and_stop();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge pclk);
        error_cnt++;
        report_and_stop();
    end
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'h1;
        t_regs();
        t_clear();
        t_clk();
        t_phase();
        report_and_stop();
    end
endmodule // tccs_top_tb
`default_nettype wire

// ===== verilog/tccs_pkg.sv
package tccs_pkg;

    localparam int TCCS_NUM_CH = 5;
    localparam int TCCS_AW = 8;

    // Register byte offsets
    localparam logic [7:0] TCCS_OFF_CTRL0 = 8'h00;
    localparam logic [7:0] TCCS_OFF_SYNC = 8'h14;
    localparam logic [7:0] TCCS_OFF_STAT = 8'h18;
    localparam logic [7:0] TCCS_CTRL_STRIDE = 8'h04;

    // Count-control register layout and reset value
    localparam int TCCS_RSV_BIT = 7;
    localparam int TCCS_CLR_LSB = 5;
    localparam int TCCS_EDGE_LSB = 3;
    localparam int TCCS_SRC_LSB = 0;
    localparam logic [7:0] TCCS_CTRL_RST = 8'h00;

    // Sync/mode register layout
    localparam int TCCS_SYNC_LSB = 0;
    localparam int TCCS_PHASE_BIT = 8;
    localparam int TCCS_PHASE_CH = 2;

    // Status register layout
    localparam int TCCS_STAT_TICK_LSB = 0;
    localparam int TCCS_STAT_CLR_LSB = 8;

    typedef enum logic [1:0] {
        TCCS_CLR_NONE = 2'b00,
        TCCS_CLR_GRA = 2'b01,
        TCCS_CLR_GRB = 2'b10,
        TCCS_CLR_SYNC = 2'b11
    } tccs_clr_t;

    typedef enum logic [2:0] {
        TCCS_SRC_DIV1 = 3'b000,
        TCCS_SRC_DIV2 = 3'b001,
        TCCS_SRC_DIV4 = 3'b010,
        TCCS_SRC_DIV8 = 3'b011,
        TCCS_SRC_EXTA = 3'b100,
        TCCS_SRC_EXTB = 3'b101,
        TCCS_SRC_EXTC = 3'b110,
        TCCS_SRC_EXTD = 3'b111
    } tccs_src_t;

    typedef struct packed {
        logic rsv;
        tccs_clr_t clr_sel;
        logic [1:0] edge_sel;
        tccs_src_t clk_src;
    } tccs_ctrl_t;

    // General register events of one channel
    typedef struct packed {
        logic gra_is_capture;
        logic gra_match;
        logic gra_capture;
        logic grb_is_capture;
        logic grb_match;
        logic grb_capture;
    } tccs_gr_evt_t;

endpackage

// ===== verilog/tccs_top.sv
// Function
// - Five 8-bit count-control registers, one per channel
// - Reset and standby restore initial value zero
// - Bit 7 reserved, writes have no effect; the register here stores bit 7 and reads it back
// - Bits 6:5 choose counter clear source
// - Clear on match or capture per role
// - Synchronized clear follows other synced channels
// - Separate sync register selects synced channels
// - Bits 4:3 choose rising, falling, both edges
// - Phase mode on channel 2 ignores edge field
// - Three-bit field selects internal or external clock
// - Internal source counts falling edges, edge ignored
// - External source counts edges chosen by field
// - Phase mode ignores channel 2 clock source
//
// Design decisions made here: the APB slave port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module tccs_top
    import tccs_pkg::*;
#(
    parameter int NUM_CH = TCCS_NUM_CH
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [TCCS_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic standby,
    input wire logic ext_count_clock_a,
    input wire logic ext_count_clock_b,
    input wire logic ext_count_clock_c,
    input wire logic ext_count_clock_d,
    input wire logic phase_count_tick,
    input wire tccs_gr_evt_t [NUM_CH-1:0] gr_evt,
    output logic [NUM_CH-1:0] count_tick,
    output logic [NUM_CH-1:0] counter_clear
);

    tccs_ctrl_t [NUM_CH-1:0] ctrl_ff;
    logic [NUM_CH-1:0] sync_sel_ff;
    logic phase_mode_ff;
    logic [2:0] div_ff;
    logic [3:0] ext_prev_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic [NUM_CH-1:0] tick_ff;
    logic [NUM_CH-1:0] clear_ff;

    // Bus decode
    wire logic access = psel && penable;
    wire logic first_access = access && !pready_ff;
    wire logic wr_commit = access && pready_ff && pwrite && !standby;
    wire logic [TCCS_AW-1:0] ctrl_end = TCCS_AW'(TCCS_OFF_CTRL0 + TCCS_CTRL_STRIDE * NUM_CH);
    wire logic hit_ctrl = (paddr[1:0] == 2'b00) && (paddr < ctrl_end);
    wire logic [TCCS_AW-3:0] ctrl_idx = paddr[TCCS_AW-1:2];
    wire logic hit_sync = paddr == TCCS_OFF_SYNC;
    wire logic hit_stat = paddr == TCCS_OFF_STAT;
    wire logic hit_any = hit_ctrl || hit_sync || hit_stat;

    // Read views of each register, upper bits zero
    logic [31:0] ctrl_rd;
    logic [31:0] sync_rd;
    logic [31:0] stat_rd;
    logic [31:0] rd_mux;

    always_comb begin
        ctrl_rd = 32'h0000_0000;
        ctrl_rd[7:0] = ctrl_ff[ctrl_idx];
    end

    always_comb begin
        sync_rd = 32'h0000_0000;
        sync_rd[TCCS_SYNC_LSB +: NUM_CH] = sync_sel_ff;
        sync_rd[TCCS_PHASE_BIT] = phase_mode_ff;
    end

    always_comb begin
        stat_rd = 32'h0000_0000;
        stat_rd[TCCS_STAT_TICK_LSB +: NUM_CH] = tick_ff;
        stat_rd[TCCS_STAT_CLR_LSB +: NUM_CH] = clear_ff;
    end

    // Unmapped offsets read as zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hit_ctrl) begin
            rd_mux = ctrl_rd;
        end else if (hit_sync) begin
            rd_mux = sync_rd;
        end else if (hit_stat) begin
            rd_mux = stat_rd;
        end
    end

    wire logic [31:0] nxt_prdata = pwrite ? 32'h0000_0000 : rd_mux;

    // Bus answer one cycle into the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
        end else begin
            pready_ff <= first_access;
        end
    end

    // Error flag stands with ready for unmapped offsets
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr_ff <= 1'b0;
        end else begin
            pslverr_ff <= first_access && !hit_any;
        end
    end

    // Read data latched once per transfer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h0000_0000;
        end else if (first_access) begin
            prdata_ff <= nxt_prdata;
        end
    end

    // Channel sync select
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_sel_ff <= '0;
        end else if (standby) begin
            sync_sel_ff <= '0;
        end else if (wr_commit && hit_sync) begin
            sync_sel_ff <= pwdata[TCCS_SYNC_LSB +: NUM_CH];
        end
    end

    // Phase counting mode bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_mode_ff <= 1'b0;
        end else if (standby) begin
            phase_mode_ff <= 1'b0;
        end else if (wr_commit && hit_sync) begin
            phase_mode_ff <= pwdata[TCCS_PHASE_BIT];
        end
    end

    // Free running prescaler
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_ff <= 3'h0;
        end else begin
            div_ff <= div_ff + 3'h1;
        end
    end

    // External pin history
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_prev_ff <= 4'h0;
        end else begin
            ext_prev_ff <= {ext_count_clock_d, ext_count_clock_c, ext_count_clock_b, ext_count_clock_a};
        end
    end

    // Internal clock falling edges occur when the divider wraps
    wire logic int_div1 = 1'b1;
    wire logic int_div2 = div_ff[0];
    wire logic int_div4 = &div_ff[1:0];
    wire logic int_div8 = &div_ff;
    wire logic [3:0] ext_now = {ext_count_clock_d, ext_count_clock_c, ext_count_clock_b, ext_count_clock_a};
    logic [3:0] ext_rise;
    logic [3:0] ext_fall;

    // A change against the last sample is one edge
    genvar pin;
    generate
        for (pin = 0; pin < 4; pin = pin + 1) begin : g_pin
            assign ext_rise[pin] = ext_now[pin] && !ext_prev_ff[pin];
            assign ext_fall[pin] = !ext_now[pin] && ext_prev_ff[pin];
        end
    endgenerate

    // Clears raised by each channel's own general register events
    logic [NUM_CH-1:0] own_clear;
    logic [NUM_CH-1:0] nxt_tick;
    logic [NUM_CH-1:0] nxt_clear;
    wire logic sync_clear_any = |(own_clear & sync_sel_ff);

    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch = ch + 1) begin : g_ch
            tccs_ctrl_t cfg;
            logic gra_evt;
            logic grb_evt;
            logic int_tick;
            logic [1:0] ext_idx;
            logic ext_tick;
            logic sel_tick;
            logic phase_ch;
            logic sync_hit;
            logic ctrl_wr;

            assign cfg = ctrl_ff[ch];
            assign phase_ch = (ch == TCCS_PHASE_CH) && phase_mode_ff;

            // Role of each general register picks the clearing event
            assign gra_evt = gr_evt[ch].gra_is_capture ? gr_evt[ch].gra_capture : gr_evt[ch].gra_match;
            assign grb_evt = gr_evt[ch].grb_is_capture ? gr_evt[ch].grb_capture : gr_evt[ch].grb_match;

            always_comb begin
                case (cfg.clr_sel)
                    TCCS_CLR_NONE: begin
                        own_clear[ch] = 1'b0;
                    end
                    TCCS_CLR_GRA: begin
                        own_clear[ch] = gra_evt;
                    end
                    TCCS_CLR_GRB: begin
                        own_clear[ch] = grb_evt;
                    end
                    TCCS_CLR_SYNC: begin
                        own_clear[ch] = 1'b0;
                    end
                    default: begin
                        own_clear[ch] = 1'b0;
                    end
                endcase
            end

            // Synced channels clear together with any own clear of a sync-selected channel
            assign sync_hit = (cfg.clr_sel == TCCS_CLR_SYNC) && sync_sel_ff[ch] && sync_clear_any;
            assign nxt_clear[ch] = own_clear[ch] || sync_hit;

            // Internal divider tap
            always_comb begin
                case (cfg.clk_src[1:0])
                    2'b00: begin
                        int_tick = int_div1;
                    end
                    2'b01: begin
                        int_tick = int_div2;
                    end
                    2'b10: begin
                        int_tick = int_div4;
                    end
                    2'b11: begin
                        int_tick = int_div8;
                    end
                    default: begin
                        int_tick = 1'b0;
                    end
                endcase
            end

            assign ext_idx = cfg.clk_src[1:0];

            // External edge choice
            always_comb begin
                case (cfg.edge_sel)
                    2'b00: begin
                        ext_tick = ext_rise[ext_idx];
                    end
                    2'b01: begin
                        ext_tick = ext_fall[ext_idx];
                    end
                    2'b10: begin
                        ext_tick = ext_rise[ext_idx] || ext_fall[ext_idx];
                    end
                    2'b11: begin
                        ext_tick = ext_rise[ext_idx] || ext_fall[ext_idx];
                    end
                    default: begin
                        ext_tick = 1'b0;
                    end
                endcase
            end

            // Internal source ignores the edge field; external obeys it
            assign sel_tick = cfg.clk_src[2] ? ext_tick : int_tick;
            assign nxt_tick[ch] = phase_ch ? phase_count_tick : sel_tick;

            // Write select of this channel's control register
            assign ctrl_wr = wr_commit && hit_ctrl && (ctrl_idx == (TCCS_AW-2)'(ch));

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    ctrl_ff[ch] <= TCCS_CTRL_RST;
                end else if (standby) begin
                    ctrl_ff[ch] <= TCCS_CTRL_RST;
                end else if (ctrl_wr) begin
                    ctrl_ff[ch] <= pwdata[7:0];
                end
            end
        end
    endgenerate

    // Per-channel count enables
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_ff <= '0;
        end else if (standby) begin
            tick_ff <= '0;
        end else begin
            tick_ff <= nxt_tick;
        end
    end

    // Per-channel counter clears
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clear_ff <= '0;
        end else if (standby) begin
            clear_ff <= '0;
        end else begin
            clear_ff <= nxt_clear;
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign count_tick = tick_ff;
    assign counter_clear = clear_ff;

endmodule // tccs_top
`default_nettype wire
